// ==== hw/cmcet_pkg.sv ====
// Package: register map, field layout, reset values and timing for the CSR slice
//--------------------------------------------------------------------
// Operation
//--------------------------------------------------------------------
// Operation
// R1: Count frames dropped for lack of descriptor
// R2: Sticky overflow flag at bit 16
// R3: Read returns count, then clears both
// R4: EEPROM read needs read bit and select
// R5: EEPROM write needs write bit and select
// R6: Select bit gates all EEPROM port access; bit 3 samples the data-in pin whatever the select bit
// R7: Bit 3 reflects EEPROM returned data
// R8: Bit 2 drives serial data to EEPROM
// R9: Software toggles bit 1 as serial clock
// R10: Bit 0 drives EEPROM chip select
// R11: Bit 16 selects continuous timer mode
// R12: Timer loads value, decrements every 204us
// R13: Bit 30 selects CRC-16 seed value
// R14: Bits 29..26 enable patterns one to four
// R15: Timer interrupt needs own and summary enable
// R16: At zero flag expiry; reload or stop
// R17: Software sequences EEPROM commands by bit-banging
package cmcet_pkg;

  //------------------------------------------------------------------
  // Register offsets
  //------------------------------------------------------------------
  localparam logic [7:0] OFF_MISSED   = 8'h40;
  localparam logic [7:0] OFF_EEPORT   = 8'h48;
  localparam logic [7:0] OFF_TIMER    = 8'h58;
  localparam logic [7:0] OFF_WAKEUP   = 8'h68;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h80;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h84;

  //------------------------------------------------------------------
  // Field positions
  //------------------------------------------------------------------
  localparam int MISS_OVF_BIT  = 16;
  localparam int EE_RD_BIT     = 14;
  localparam int EE_WR_BIT     = 13;
  localparam int EE_SEL_BIT    = 11;
  localparam int EE_DOUT_BIT   = 3;
  localparam int EE_DIN_BIT    = 2;
  localparam int EE_CLK_BIT    = 1;
  localparam int EE_CS_BIT     = 0;
  localparam int TMR_CONT_BIT  = 16;
  localparam int WK_CRC_BIT    = 30;
  localparam int WK_PAT_LO_BIT = 26;
  localparam int IRQ_TMR_BIT   = 0;
  localparam int IRQ_OVF_BIT   = 1;
  localparam int IEN_TMR_BIT   = 11;
  localparam int IEN_ABN_BIT   = 15;

  //------------------------------------------------------------------
  // Reset values
  //------------------------------------------------------------------
  localparam logic        EE_DIN_RST  = 1'b1;
  localparam logic        EE_CLK_RST  = 1'b1;
  localparam logic        EE_CS_RST   = 1'b1;
  localparam logic        EE_DOUT_RST = 1'b1;
  localparam logic [15:0] CRC_SEED_0  = 16'h0000;
  localparam logic [15:0] CRC_SEED_1  = 16'hFFFF;

  //------------------------------------------------------------------
  // Timing
  //------------------------------------------------------------------
  localparam int CLK_MHZ      = 50;
  localparam int TICK_US      = 204;
  localparam int TICK_CYCLES  = TICK_US * CLK_MHZ;
  localparam logic [13:0] TICK_LAST = 14'(TICK_CYCLES - 1);

  //------------------------------------------------------------------
  // Carriers
  //------------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } cmcet_bus_s;

  typedef struct packed {
    logic rd_en;
    logic wr_en;
    logic sel;
    logic din;
    logic clk;
    logic cs;
  } cmcet_eeport_s;

endpackage

// ==== hw/cmcet_top.sv ====
// Top: CSR slice with missed-frame counter, EEPROM port, timer, wake-up control
`timescale 1ns/1ns
`default_nettype none
module cmcet_top (
  input  wire logic        MCLK,
  input  wire logic        RESETN,
  input  wire logic        CE,
  input  wire logic [7:0]  ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output var  logic [31:0] RDATA,
  input  wire logic        FRAME_DROP,
  input  wire logic        EE_DATA_IN,
  output var  logic        EE_CS,
  output var  logic        EE_CLK,
  output var  logic        EE_DATA_OUT,
  output var  logic        EE_RD_EN,
  output var  logic        EE_WR_EN,
  input  wire logic        TIMER_IRQ_EN,
  input  wire logic        ABNORMAL_EN,
  output var  logic        TIMER_IRQ,
  output var  logic        IRQ,
  output var  logic [15:0] CRC_SEED,
  output var  logic [3:0]  PATTERN_EN
);

  //------------------------------------------------------------------
  // Helpers
  //------------------------------------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  cmcet_pkg::cmcet_bus_s    bus;
  cmcet_pkg::cmcet_eeport_s ee_r;
  logic [15:0] miss_cnt_r;
  logic        miss_ovf_r;
  logic        ee_dout_r;
  logic        tmr_cont_r;
  logic [15:0] tmr_load_r;
  logic [15:0] tmr_cnt_r;
  logic        tmr_run_r;
  logic [13:0] tick_r;
  logic        crc_sel_r;
  logic [3:0]  pat_en_r;
  logic [1:0]  irq_stat_r;
  logic [1:0]  irq_mask_r;
  logic        tmr_exp;
  logic        miss_wrap;
  logic        rd_miss;
  logic        tick_end;
  logic        wr_eeport;
  logic        wr_timer;
  logic        wr_wakeup;
  logic        wr_irq_stat;
  logic        wr_irq_mask;
  logic [1:0]  irq_clr;
  logic [1:0]  irq_set;

  //------------------------------------------------------------------
  // Bus decode and events
  //------------------------------------------------------------------
  assign bus         = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};
  assign rd_miss     = bus.rd && hit(bus.addr, cmcet_pkg::OFF_MISSED);
  assign wr_eeport   = bus.wr && hit(bus.addr, cmcet_pkg::OFF_EEPORT);
  assign wr_timer    = bus.wr && hit(bus.addr, cmcet_pkg::OFF_TIMER);
  assign wr_wakeup   = bus.wr && hit(bus.addr, cmcet_pkg::OFF_WAKEUP);
  assign wr_irq_stat = bus.wr && hit(bus.addr, cmcet_pkg::OFF_IRQ_STAT);
  assign wr_irq_mask = bus.wr && hit(bus.addr, cmcet_pkg::OFF_IRQ_MASK);
  assign miss_wrap   = FRAME_DROP && (miss_cnt_r == 16'hFFFF);
  assign tick_end    = tmr_run_r && (tick_r == cmcet_pkg::TICK_LAST);
  assign tmr_exp     = tick_end && (tmr_cnt_r == 16'h0001);
  assign irq_clr     = wr_irq_stat ? bus.wdata[1:0] : 2'h0;
  // No overflow in a read cycle: the read restarts the count
  assign irq_set     = {miss_wrap && !rd_miss, tmr_exp};

  //------------------------------------------------------------------
  // Missed-frame counter
  //------------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      miss_cnt_r <= 16'h0000;
      miss_ovf_r <= 1'b0;
    end else if (CE) begin
      if (rd_miss) begin
        // A drop in the read cycle starts the next count, so none is lost
        miss_cnt_r <= {15'h0000, FRAME_DROP}; // R3 R1
        miss_ovf_r <= 1'b0; // R3
      end else begin
        if (FRAME_DROP) begin
          miss_cnt_r <= miss_cnt_r + 16'h0001; // R1
        end
        if (miss_wrap) begin
          miss_ovf_r <= 1'b1; // R2
        end
      end
    end
  end

  //------------------------------------------------------------------
  // Serial EEPROM port
  //------------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      ee_r.rd_en <= 1'b0;
      ee_r.wr_en <= 1'b0;
      ee_r.sel   <= 1'b0;
      ee_r.din   <= cmcet_pkg::EE_DIN_RST;
      ee_r.clk   <= cmcet_pkg::EE_CLK_RST;
      ee_r.cs    <= cmcet_pkg::EE_CS_RST;
    end else if (CE && wr_eeport) begin
      ee_r.rd_en <= bus.wdata[cmcet_pkg::EE_RD_BIT];
      ee_r.wr_en <= bus.wdata[cmcet_pkg::EE_WR_BIT];
      ee_r.sel   <= bus.wdata[cmcet_pkg::EE_SEL_BIT];
      ee_r.din   <= bus.wdata[cmcet_pkg::EE_DIN_BIT]; // R8
      ee_r.clk   <= bus.wdata[cmcet_pkg::EE_CLK_BIT]; // R9
      ee_r.cs    <= bus.wdata[cmcet_pkg::EE_CS_BIT]; // R10
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      ee_dout_r <= cmcet_pkg::EE_DOUT_RST;
    end else if (CE) begin
      ee_dout_r <= EE_DATA_IN; // R7
    end
  end

  // Pins follow the register only while the port is selected
  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      EE_CS       <= 1'b0;
      EE_CLK      <= 1'b0;
      EE_DATA_OUT <= 1'b0;
      EE_RD_EN    <= 1'b0;
      EE_WR_EN    <= 1'b0;
    end else if (CE) begin
      EE_CS       <= ee_r.sel && ee_r.cs; // R6 R10
      EE_CLK      <= ee_r.sel && ee_r.clk; // R6 R9
      EE_DATA_OUT <= ee_r.sel && ee_r.din; // R6 R8
      EE_RD_EN    <= ee_r.sel && ee_r.rd_en; // R4
      EE_WR_EN    <= ee_r.sel && ee_r.wr_en; // R5
    end
  end

  //------------------------------------------------------------------
  // General-purpose timer
  //------------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      tmr_cont_r <= 1'b0;
      tmr_load_r <= 16'h0000;
      tmr_cnt_r  <= 16'h0000;
      tmr_run_r  <= 1'b0;
    end else if (CE) begin
      if (wr_timer) begin
        tmr_cont_r <= bus.wdata[cmcet_pkg::TMR_CONT_BIT]; // R11
        tmr_load_r <= bus.wdata[15:0]; // R12
        tmr_cnt_r  <= bus.wdata[15:0]; // R12
        tmr_run_r  <= bus.wdata[15:0] != 16'h0000;
      end else if (tick_end) begin
        if (tmr_exp) begin
          tmr_cnt_r <= tmr_cont_r ? tmr_load_r : 16'h0000; // R16 R11
          tmr_run_r <= tmr_cont_r; // R16
        end else begin
          tmr_cnt_r <= tmr_cnt_r - 16'h0001; // R12
        end
      end
    end
  end

  // Prescaler restarts on every load so the first period is a full one
  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      tick_r <= 14'h0000;
    end else if (CE) begin
      if (wr_timer || tick_end) begin
        tick_r <= 14'h0000;
      end else if (tmr_run_r) begin
        tick_r <= tick_r + 14'h0001; // R12
      end
    end
  end

  //------------------------------------------------------------------
  // Wake-up control
  //------------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      crc_sel_r <= 1'b0;
      pat_en_r  <= 4'h0;
    end else if (CE && wr_wakeup) begin
      crc_sel_r <= bus.wdata[cmcet_pkg::WK_CRC_BIT]; // R13
      pat_en_r  <= bus.wdata[cmcet_pkg::WK_PAT_LO_BIT +: 4]; // R14
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      CRC_SEED   <= cmcet_pkg::CRC_SEED_0;
      PATTERN_EN <= 4'h0;
    end else if (CE) begin
      CRC_SEED   <= crc_sel_r ? cmcet_pkg::CRC_SEED_1 : cmcet_pkg::CRC_SEED_0; // R13
      // Bit 3 is pattern one (bit 29) down to pattern four (bit 26)
      PATTERN_EN <= pat_en_r; // R14
    end
  end

  //------------------------------------------------------------------
  // Interrupts
  //------------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      irq_stat_r <= 2'h0;
    end else if (CE) begin
      // Hardware set wins over write-one-to-clear in the same cycle
      irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set; // R16 R2
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      irq_mask_r <= 2'h0;
    end else if (CE && wr_irq_mask) begin
      irq_mask_r <= bus.wdata[1:0];
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      TIMER_IRQ <= 1'b0;
      IRQ       <= 1'b0;
    end else if (CE) begin
      TIMER_IRQ <= irq_stat_r[cmcet_pkg::IRQ_TMR_BIT] && TIMER_IRQ_EN && ABNORMAL_EN; // R15
      IRQ       <= |(irq_stat_r & irq_mask_r);
    end
  end

  //------------------------------------------------------------------
  // Read port
  //------------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      RDATA <= 32'h0000_0000;
    end else if (CE) begin
      RDATA <= 32'h0000_0000;
      if (bus.rd) begin
        unique case (1'b1)
          hit(bus.addr, cmcet_pkg::OFF_MISSED):
            RDATA <= {15'h0000, miss_ovf_r, miss_cnt_r}; // R3
          hit(bus.addr, cmcet_pkg::OFF_EEPORT):
            RDATA <= {17'h00000, ee_r.rd_en, ee_r.wr_en, 1'b0, ee_r.sel, 7'h00,
                      ee_dout_r, ee_r.din, ee_r.clk, ee_r.cs}; // R7
          hit(bus.addr, cmcet_pkg::OFF_TIMER):
            RDATA <= {15'h0000, tmr_cont_r, tmr_cnt_r};
          hit(bus.addr, cmcet_pkg::OFF_WAKEUP):
            RDATA <= {1'b0, crc_sel_r, pat_en_r, 26'h0000000};
          hit(bus.addr, cmcet_pkg::OFF_IRQ_STAT):
            RDATA <= {30'h00000000, irq_stat_r};
          hit(bus.addr, cmcet_pkg::OFF_IRQ_MASK):
            RDATA <= {30'h00000000, irq_mask_r};
          default:
            RDATA <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule // cmcet_top
`default_nettype wire

// ==== verification/cmcet_eeprom_model.sv ====
// Serial EEPROM stand-in: echoes the last bit clocked in
`timescale 1ns/1ns
`default_nettype none
module cmcet_eeprom_model (
  input  wire logic cs,
  input  wire logic sclk,
  input  wire logic din,
  output var  logic dout
);
  logic q_r;
  initial q_r = 1'b0;
  always @(posedge sclk) begin
    if (cs) q_r <= din;
  end
  // Data line pulled up while deselected
  always_comb dout = cs ? q_r : 1'b1;
endmodule // cmcet_eeprom_model
`default_nettype wire

// ==== verification/cmcet_top_props.sv ====
// Checker: port-level properties of the CSR slice
`timescale 1ns/1ns
`default_nettype none
module cmcet_top_props (
  input wire logic        MCLK,
  input wire logic        RESETN,
  input wire logic        CE,
  input wire logic [7:0]  ADDR,
  input wire logic [31:0] WDATA,
  input wire logic        WR,
  input wire logic        RD,
  input wire logic [31:0] RDATA,
  input wire logic        FRAME_DROP,
  input wire logic        EE_CS,
  input wire logic        EE_CLK,
  input wire logic        EE_DATA_OUT,
  input wire logic        EE_RD_EN,
  input wire logic        EE_WR_EN,
  input wire logic        TIMER_IRQ_EN,
  input wire logic        ABNORMAL_EN,
  input wire logic        TIMER_IRQ,
  input wire logic [15:0] CRC_SEED
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RESETN);
  a_rdata_idle_zero: assert property (CE && !RD |=> RDATA == 32'h0)
    else $error("read data not zero outside a read");
  a_miss_read_clear: assert property (CE && RD && ADDR == 8'h40 ##1 CE && RD && ADDR == 8'h40
    |=> RDATA == {31'h0, $past(FRAME_DROP,2)}) else $error("missed counter not cleared by read");
  a_ee_rd_gate: assert property (
    $past(WR,2) && $past(ADDR,2) == 8'h48 && $past(CE,2) && $past(CE)
    |-> EE_RD_EN == ($past(WDATA[14],2) & $past(WDATA[11],2))) else $error("read enable pin");
  a_ee_wr_gate: assert property (
    $past(WR,2) && $past(ADDR,2) == 8'h48 && $past(CE,2) && $past(CE)
    |-> EE_WR_EN == ($past(WDATA[13],2) & $past(WDATA[11],2))) else $error("write enable pin");
  a_ee_cs_gate: assert property (
    $past(WR,2) && $past(ADDR,2) == 8'h48 && $past(CE,2) && $past(CE)
    |-> EE_CS == ($past(WDATA[0],2) & $past(WDATA[11],2))) else $error("chip select pin");
  a_ee_clk_gate: assert property (
    $past(WR,2) && $past(ADDR,2) == 8'h48 && $past(CE,2) && $past(CE)
    |-> EE_CLK == ($past(WDATA[1],2) & $past(WDATA[11],2))) else $error("serial clock pin");
  a_ee_dout_drive: assert property (
    $past(WR,2) && $past(ADDR,2) == 8'h48 && $past(CE,2) && $past(CE)
    |-> EE_DATA_OUT == ($past(WDATA[2],2) & $past(WDATA[11],2))) else $error("serial data pin");
  a_timer_irq_gate: assert property ($past(CE) && TIMER_IRQ |-> $past(TIMER_IRQ_EN) && $past(ABNORMAL_EN))
    else $error("timer interrupt without both enables");
  a_crc_seed_val: assert property (
    $past(WR,2) && $past(ADDR,2) == 8'h68 && $past(CE,2) && $past(CE)
    |-> CRC_SEED == {16{$past(WDATA[30],2)}}) else $error("seed does not follow select bit");
  a_freeze_hold: assert property (!CE && RESETN
    |=> $stable(RDATA) && $stable(EE_CS) && $stable(EE_CLK) && $stable(CRC_SEED)
    && $stable(TIMER_IRQ)) else $error("outputs moved while clock enable low");
endmodule // cmcet_top_props
bind cmcet_top cmcet_top_props u_props (.MCLK(MCLK), .RESETN(RESETN), .CE(CE), .ADDR(ADDR),
  .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .FRAME_DROP(FRAME_DROP),
  .EE_CS(EE_CS), .EE_CLK(EE_CLK),
  .EE_DATA_OUT(EE_DATA_OUT), .EE_RD_EN(EE_RD_EN), .EE_WR_EN(EE_WR_EN),
  .TIMER_IRQ_EN(TIMER_IRQ_EN), .ABNORMAL_EN(ABNORMAL_EN), .TIMER_IRQ(TIMER_IRQ),
  .CRC_SEED(CRC_SEED));
`default_nettype wire

// ==== verification/cmcet_top_tb.sv ====
// Testbench: register, EEPROM port, counter, timer and interrupt checks
`timescale 1ns/1ns
`default_nettype none
module cmcet_top_tb;
  logic mclk, resetn, ce, wr, rd, rd_d, drop, ee_in, cs, sck, dout, rd_en, wr_en;
  logic tie, abn, tirq, irq;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, seed, d, exp_q[$];
  logic [15:0] crc;
  logic [3:0]  pat;
  int n_errors, comparisons, cyc, n, i;
  cmcet_top DUT (.MCLK(mclk), .RESETN(resetn), .CE(ce), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .FRAME_DROP(drop), .EE_DATA_IN(ee_in), .EE_CS(cs), .EE_CLK(sck),
    .EE_DATA_OUT(dout), .EE_RD_EN(rd_en), .EE_WR_EN(wr_en), .TIMER_IRQ_EN(tie),
    .ABNORMAL_EN(abn), .TIMER_IRQ(tirq), .IRQ(irq), .CRC_SEED(crc), .PATTERN_EN(pat));
  cmcet_eeprom_model u_ee (.cs(cs), .sclk(sck), .din(dout), .dout(ee_in));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk);
    wr <= w;
    rd <= r;
    addr <= a;
    wdata <= v;
  endtask
  task automatic bus_rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, 1'b1, a, rnd());
  endtask
  task automatic pause(input int c);
    bus(1'b0, 1'b0, 8'h00, 32'h0);
    repeat (c) @(posedge mclk);
  endtask
  task automatic finish_test();
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge mclk) begin
    if (rd_d) check(rdata, exp_q.pop_front());
    rd_d <= rd;
    cyc++;
    if (cyc == 90000) begin
      n_errors++;
      finish_test();
    end
  end
  initial begin
    mclk = 0;
    forever #10 mclk = ~mclk;
  end
  //----------------------------------------------------------------
  // Main sequence
  //----------------------------------------------------------------
  initial begin
    {resetn, wr, rd, drop, abn, addr, wdata} = '0;
    {ce, tie} = 2'b11;
    seed = 32'hbb34e1c4;
    repeat (10) @(posedge mclk);
    resetn <= 1'b1;
    bus_rd(8'h40, 32'h0);
    bus_rd(8'h48, 32'hF);
    bus_rd(8'h58, 32'h0);
    bus_rd(8'h68, 32'h0);
    bus(1'b1, 1'b0, 8'hFC, rnd());
    bus_rd(8'hFC, 32'h0);
    for (i = 0; i < 2; i++) begin
      n = 32'(rnd() & 32'h4);
      bus(1'b1, 1'b0, 8'h48, 32'h6801 | n);
      bus(1'b1, 1'b0, 8'h48, 32'h6803 | n);
      pause(6);
      bus_rd(8'h48, 32'h6803 | n | (n << 1));
    end
    bus(1'b1, 1'b0, 8'h48, 32'h6007);
    pause(6);
    bus_rd(8'h48, 32'h600F);
    for (i = 0; i < 4; i++) begin
      d = rnd();
      bus(1'b1, 1'b0, 8'h68, d);
      pause(4);
      check({16'h0, crc}, {16'h0, {16{d[30]}}});
      check({28'h0, pat}, {28'h0, d[29:26]});
      bus_rd(8'h68, d & 32'h7C000000);
    end
    pause(1);
    ce <= 1'b0;
    drop <= 1'b1;
    bus(1'b1, 1'b0, 8'h68, ~d);
    pause(2);
    ce <= 1'b1;
    drop <= 1'b0;
    bus_rd(8'h68, d & 32'h7C000000);
    pause(1);
    n = 3 + 32'(rnd() % 13);
    repeat (n) begin
      drop <= 1'b1;
      @(posedge mclk);
      drop <= 1'b0;
      @(posedge mclk);
    end
    bus_rd(8'h40, 32'(n));
    bus_rd(8'h40, 32'h0);
    pause(1);
    drop <= 1'b1;
    repeat (65536) @(posedge mclk);
    drop <= 1'b0;
    bus_rd(8'h40, 32'h10000);
    bus_rd(8'h40, 32'h0);
    bus_rd(8'h80, 32'h2);
    bus(1'b1, 1'b0, 8'h84, 32'h2);
    pause(3);
    check({31'h0, irq}, 32'h1);
    bus(1'b1, 1'b0, 8'h80, 32'h2);
    pause(3);
    check({31'h0, irq}, 32'h0);
    bus(1'b1, 1'b0, 8'h84, 32'h1);
    bus(1'b1, 1'b0, 8'h58, 32'h10001);
    pause(1);
    for (i = 0; i < 10500 && irq !== 1'b1; i++) @(posedge mclk);
    check({31'h0, irq}, 32'h1);
    check({31'h0, tirq}, 32'h0);
    abn <= 1'b1;
    pause(3);
    check({31'h0, tirq}, 32'h1);
    tie <= 1'b0;
    pause(3);
    check({31'h0, tirq}, 32'h0);
    bus_rd(8'h58, 32'h10001);
    bus_rd(8'h80, 32'h1);
    bus(1'b1, 1'b0, 8'h58, 32'h0);
    pause(4);
    finish_test();
  end
endmodule // cmcet_top_tb
`default_nettype wire
